//--- src/dewg_top.sv
// Write guard and register file for the on-chip data nonvolatile store
//
// What this block does
// - Write starts only after 55h, AAh, trigger
// - Each byte needs its own full unlock
// - Exact cycle spacing across unlock, else refused
// - Trigger ignored unless permit already set
// - Only software changes the permit bit
// - Clearing permit never aborts a running write
// - Completion clears trigger, sets done bit 7
// - Done flag sticky until software clears it
// - Power-up leaves permit cleared
// - No write while power-up timer runs
// - Readout lock leaves CPU access intact
// - Unlock key port holds no storage
// - Triggers set-only by software, hardware clears
// - Reset during write sets abort flag
// - Key port always reads zero
// - Read data in byte register next cycle
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dewg_top #(
    parameter int PWRT_CYC = dewg_pkg::PWRT_CYC,
    parameter int PROG_CYC = dewg_pkg::PROG_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic cpuResetReq,
    input wire logic dataReadoutLock,
    input wire dewg_pkg::dewg_bus_type busReq,
    output logic [7:0] rdData_q,
    output logic nvmBusy_q,
    output logic pwrtRunning_q,
    output logic extReadAllow_q
);
    logic rstMeta_q;
    logic rstN;
    logic lockMeta_q;
    logic lockSync_q;
    logic [7:0] coreIrq_q;
    logic [7:0] flags_q;
    logic [7:0] masks_q;
    logic [7:0] nvmByte_q;
    logic [7:0] nvmLoc_q;
    logic permit_q;
    logic abort_q;
    logic rdTrig_q;
    logic [dewg_pkg::TIMER_W-1:0] progCnt_q;
    logic [dewg_pkg::TIMER_W-1:0] pwrtCnt_q;
    dewg_pkg::dewg_unlock_type unlock_q;
    logic [2:0] gapCnt_q;
    logic [7:0] memRdData;
    logic [7:0] rdMux;
    logic wrFlags;
    logic wrMasks;
    logic wrCore;
    logic wrByte;
    logic wrLoc;
    logic wrCtrl;
    logic wrKey;
    logic startWr;
    logic startRd;
    logic progDone;

    function automatic logic hit(input logic stb, input logic [2:0] addr,
                                 input logic [2:0] ofs);
        hit = stb && (addr == ofs);
    endfunction

    // Reset release through two flops so no flop leaves reset on a ragged edge
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_q <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstN <= rstMeta_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            lockMeta_q <= 1'b0;
            lockSync_q <= 1'b0;
        end else if (clkEn) begin
            lockMeta_q <= dataReadoutLock;
            lockSync_q <= lockMeta_q;
        end
    end

    // Lock only gates the external readout path, never the CPU side
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            extReadAllow_q <= 1'b0;
        end else if (clkEn) begin
            extReadAllow_q <= !lockSync_q;
        end
    end

    assign wrCore = hit(busReq.wrStb, busReq.addr, dewg_pkg::OFS_CORE_IRQ);
    assign wrFlags = hit(busReq.wrStb, busReq.addr, dewg_pkg::OFS_PERIPH_FLAGS);
    assign wrMasks = hit(busReq.wrStb, busReq.addr, dewg_pkg::OFS_PERIPH_MASKS);
    assign wrByte = hit(busReq.wrStb, busReq.addr, dewg_pkg::OFS_NVM_BYTE);
    assign wrLoc = hit(busReq.wrStb, busReq.addr, dewg_pkg::OFS_NVM_LOCATION);
    assign wrCtrl = hit(busReq.wrStb, busReq.addr, dewg_pkg::OFS_NVM_CONTROL);
    assign wrKey = hit(busReq.wrStb, busReq.addr, dewg_pkg::OFS_UNLOCK_KEY);

    assign startWr = wrCtrl && busReq.wrData[dewg_pkg::WRTRIG_BIT]
        && permit_q
        && unlock_q == dewg_pkg::UNLOCK_SECOND
        && gapCnt_q == dewg_pkg::TRIG_GAP_CYC
        && !pwrtRunning_q
        && !nvmBusy_q && !cpuResetReq;
    assign startRd = wrCtrl && busReq.wrData[dewg_pkg::RDTRIG_BIT]
        && !nvmBusy_q && !cpuResetReq;
    assign progDone = nvmBusy_q && progCnt_q == '0 && !cpuResetReq;

    // Power-up timer runs once after power-on release only
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            pwrtRunning_q <= 1'b1;
            pwrtCnt_q <= '0;
        end else if (clkEn && pwrtRunning_q) begin
            if (pwrtCnt_q == dewg_pkg::TIMER_W'(PWRT_CYC - 1)) begin
                pwrtRunning_q <= 1'b0;
            end else begin
                pwrtCnt_q <= pwrtCnt_q + 1'b1;
            end
        end
    end

    // Key tracker; the key port itself stores nothing, only this state moves
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            unlock_q <= dewg_pkg::UNLOCK_IDLE;
            gapCnt_q <= '0;
        end else if (clkEn) begin
            if (cpuResetReq) begin
                unlock_q <= dewg_pkg::UNLOCK_IDLE;
                gapCnt_q <= '0;
            end else if (busReq.wrStb) begin
                gapCnt_q <= 3'h1;
                if (wrKey && busReq.wrData == dewg_pkg::KEY_FIRST) begin
                    unlock_q <= dewg_pkg::UNLOCK_FIRST;
                end else if (wrKey && busReq.wrData == dewg_pkg::KEY_SECOND
                        && unlock_q == dewg_pkg::UNLOCK_FIRST
                        && gapCnt_q == dewg_pkg::KEY_GAP_CYC) begin
                    unlock_q <= dewg_pkg::UNLOCK_SECOND;
                end else begin
                    // Trigger write also lands here, so one unlock buys one byte
                    unlock_q <= dewg_pkg::UNLOCK_IDLE;
                end
            end else if (gapCnt_q != dewg_pkg::GAP_SAT) begin
                gapCnt_q <= gapCnt_q + 3'h1;
            end
        end
    end

    // Write trigger: set-only by software, cleared by completion or reset
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            nvmBusy_q <= 1'b0;
            progCnt_q <= '0;
        end else if (clkEn) begin
            if (cpuResetReq) begin
                nvmBusy_q <= 1'b0;
            end else if (startWr) begin
                nvmBusy_q <= 1'b1;
                progCnt_q <= dewg_pkg::TIMER_W'(PROG_CYC - 1);
            end else if (nvmBusy_q) begin
                // Permit plays no part here once the cycle runs
                if (progCnt_q == '0) begin
                    nvmBusy_q <= 1'b0;
                end else begin
                    progCnt_q <= progCnt_q - 1'b1;
                end
            end
        end
    end

    // Read trigger lives one cycle, the array answers in that cycle
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            rdTrig_q <= 1'b0;
        end else if (clkEn) begin
            rdTrig_q <= startRd;
        end
    end

    // Permit and abort flag: no hardware path clears permit except reset
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            permit_q <= 1'b0;
            abort_q <= 1'b0;
        end else if (clkEn) begin
            if (cpuResetReq) begin
                permit_q <= 1'b0;
                if (nvmBusy_q) begin
                    abort_q <= 1'b1;
                end
            end else if (wrCtrl) begin
                permit_q <= busReq.wrData[dewg_pkg::PERMIT_BIT];
                abort_q <= busReq.wrData[dewg_pkg::ABORT_BIT];
            end
        end
    end

    // Location and byte ignore software writes while a write runs; a read trigger given with the write trigger still reloads the byte
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            nvmLoc_q <= dewg_pkg::RST_BYTE;
        end else if (clkEn) begin
            if (cpuResetReq) begin
                nvmLoc_q <= dewg_pkg::RST_BYTE;
            end else if (wrLoc && !nvmBusy_q) begin
                nvmLoc_q <= busReq.wrData;
            end
        end
    end

    // A software write in the read-return cycle wins, being the newer value
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            nvmByte_q <= dewg_pkg::RST_BYTE;
        end else if (clkEn) begin
            if (cpuResetReq) begin
                nvmByte_q <= dewg_pkg::RST_BYTE;
            end else if (wrByte && !nvmBusy_q) begin
                nvmByte_q <= busReq.wrData;
            end else if (rdTrig_q) begin
                nvmByte_q <= memRdData;
            end
        end
    end

    // Done flag: hardware set beats a software clear in the same cycle
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            flags_q <= dewg_pkg::RST_BYTE;
        end else if (clkEn) begin
            if (cpuResetReq) begin
                flags_q <= dewg_pkg::RST_BYTE;
            end else begin
                if (wrFlags) begin
                    flags_q <= busReq.wrData;
                end
                if (progDone) begin
                    flags_q[dewg_pkg::DONE_BIT] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            coreIrq_q <= dewg_pkg::RST_BYTE;
            masks_q <= dewg_pkg::RST_BYTE;
        end else if (clkEn) begin
            if (cpuResetReq) begin
                coreIrq_q <= dewg_pkg::RST_BYTE;
                masks_q <= dewg_pkg::RST_BYTE;
            end else begin
                if (wrCore) begin
                    coreIrq_q <= busReq.wrData;
                end
                if (wrMasks) begin
                    masks_q <= busReq.wrData;
                end
            end
        end
    end

    dewg_mem dewg_mem_inst (
        .clk(sys_clk),
        .rstN(rstN),
        .clkEn(clkEn),
        .program_permit(progDone),
        .wrAddr(nvmLoc_q),
        .wrData(nvmByte_q),
        .rdEn(startRd),
        .rdAddr(nvmLoc_q),
        .rdData_q(memRdData)
    );

    always_comb begin
        rdMux = 8'h00;
        unique case (busReq.addr)
            dewg_pkg::OFS_CORE_IRQ: rdMux = coreIrq_q;
            dewg_pkg::OFS_PERIPH_FLAGS: rdMux = flags_q;
            dewg_pkg::OFS_PERIPH_MASKS: rdMux = masks_q;
            dewg_pkg::OFS_NVM_BYTE: rdMux = rdTrig_q ? memRdData : nvmByte_q;
            dewg_pkg::OFS_NVM_LOCATION: rdMux = nvmLoc_q;
            dewg_pkg::OFS_NVM_CONTROL: rdMux = {4'h0, abort_q, permit_q, nvmBusy_q, rdTrig_q};
            dewg_pkg::OFS_UNLOCK_KEY: rdMux = 8'h00;
            default: rdMux = 8'h00;
        endcase
    end

    // Read data stand for exactly one cycle, zero otherwise
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            rdData_q <= 8'h00;
        end else if (clkEn) begin
            rdData_q <= busReq.rdStb ? rdMux : 8'h00;
        end
    end

    default clocking dewg_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstN || !clkEn);

    start_after_key_a: assert property (
        $rose(nvmBusy_q) |-> $past(unlock_q) == dewg_pkg::UNLOCK_SECOND
    ) else $error("write started without both keys");

    one_byte_key_a: assert property (
        $rose(nvmBusy_q) |-> unlock_q == dewg_pkg::UNLOCK_IDLE
    ) else $error("unlock survived a started write");

    key_gap_exact_a: assert property (
        $rose(nvmBusy_q) |-> $past(gapCnt_q) == dewg_pkg::TRIG_GAP_CYC
    ) else $error("write started with wrong trigger spacing");

    start_permit_a: assert property (
        $rose(nvmBusy_q) |-> $past(permit_q)
    ) else $error("write started with permit clear");

    permit_hold_a: assert property (
        !wrCtrl && !cpuResetReq |=> $stable(permit_q)
    ) else $error("permit changed without software");

    busy_hold_a: assert property (
        nvmBusy_q && progCnt_q != '0 && !cpuResetReq |=> nvmBusy_q
    ) else $error("write cycle ended early");

    done_flag_a: assert property (
        progDone |=> !nvmBusy_q && flags_q[dewg_pkg::DONE_BIT]
    ) else $error("completion did not clear trigger and set done");

    done_sticky_a: assert property (
        flags_q[dewg_pkg::DONE_BIT] && !wrFlags && !cpuResetReq
            |=> flags_q[dewg_pkg::DONE_BIT]
    ) else $error("done flag dropped without software");

    pwrt_block_a: assert property (
        pwrtRunning_q |=> !$rose(nvmBusy_q)
    ) else $error("write started during power-up timer");

    abort_flag_a: assert property (
        cpuResetReq && nvmBusy_q |=> abort_q && !nvmBusy_q
    ) else $error("reset during write did not flag abort");

    key_read_zero_a: assert property (
        busReq.rdStb && busReq.addr == dewg_pkg::OFS_UNLOCK_KEY |=> rdData_q == 8'h00
    ) else $error("key port read nonzero");

    loc_frozen_a: assert property (
        nvmBusy_q && !cpuResetReq |=> $stable(nvmLoc_q)
    ) else $error("location changed during write");

    write_start_c: cover property ($rose(nvmBusy_q));
    write_done_c: cover property (progDone ##1 flags_q[dewg_pkg::DONE_BIT]);
    write_abort_c: cover property (cpuResetReq && nvmBusy_q);
    read_back_c: cover property (rdTrig_q ##1 busReq.rdStb);
endmodule
`default_nettype wire

//--- src/dewg_pkg.sv
// Constants, state codes and bus carrier for the data nonvolatile write guard
package dewg_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 256;
    localparam int TIMER_W = 23;

    localparam logic [2:0] OFS_CORE_IRQ = 3'h0;
    localparam logic [2:0] OFS_PERIPH_FLAGS = 3'h1;
    localparam logic [2:0] OFS_PERIPH_MASKS = 3'h2;
    localparam logic [2:0] OFS_NVM_BYTE = 3'h3;
    localparam logic [2:0] OFS_NVM_LOCATION = 3'h4;
    localparam logic [2:0] OFS_NVM_CONTROL = 3'h5;
    localparam logic [2:0] OFS_UNLOCK_KEY = 3'h6;

    localparam int DONE_BIT = 7;
    localparam int ABORT_BIT = 3;
    localparam int PERMIT_BIT = 2;
    localparam int WRTRIG_BIT = 1;
    localparam int RDTRIG_BIT = 0;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Elapsed cycles between the key writes and between second key and trigger
    localparam logic [2:0] KEY_GAP_CYC = 3'h2;
    localparam logic [2:0] TRIG_GAP_CYC = 3'h2;
    localparam logic [2:0] GAP_SAT = 3'h7;

    localparam int CLK_PERIOD_NS = 8;
    localparam int PWRT_MS = 64;
    localparam int PWRT_CYC = (PWRT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_US = 5000;
    localparam int PROG_CYC = (PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        UNLOCK_IDLE = 3'b001,
        UNLOCK_FIRST = 3'b010,
        UNLOCK_SECOND = 3'b100
    } dewg_unlock_type;

    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
    } dewg_bus_type;
endpackage

//--- src/dewg_mem.sv
// Byte array of the data nonvolatile store with a registered read port
`timescale 1ns/1ps
`default_nettype none
module dewg_mem (
    input wire logic clk,
    input wire logic rstN,
    input wire logic clkEn,
    input wire logic program_permit,
    input wire logic [7:0] wrAddr,
    input wire logic [7:0] wrData,
    input wire logic rdEn,
    input wire logic [7:0] rdAddr,
    output logic [7:0] rdData_q
);
    logic [7:0] cells [dewg_pkg::MEM_DEPTH];

    // Array carries no reset, contents survive every reset like the real cells
    always_ff @(posedge clk) begin
        if (clkEn && program_permit) begin
            cells[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rdData_q <= dewg_pkg::RST_BYTE;
        end else if (clkEn && rdEn) begin
            rdData_q <= cells[rdAddr];
        end
    end
endmodule
`default_nettype wire

//--- testbench/tb_dewg_top.sv
// Self-checking bench for the data nonvolatile write guard
`timescale 1ns/1ps
`default_nettype none
module tb_dewg_top;
    localparam int PWRT = 20;
    localparam int PROG = 10;
    localparam logic [2:0] CORE = dewg_pkg::OFS_CORE_IRQ;
    localparam logic [2:0] FLAGS = dewg_pkg::OFS_PERIPH_FLAGS;
    localparam logic [2:0] MASKS = dewg_pkg::OFS_PERIPH_MASKS;
    localparam logic [2:0] BYTE = dewg_pkg::OFS_NVM_BYTE;
    localparam logic [2:0] LOC = dewg_pkg::OFS_NVM_LOCATION;
    localparam logic [2:0] CTRL = dewg_pkg::OFS_NVM_CONTROL;
    localparam logic [2:0] KEY = dewg_pkg::OFS_UNLOCK_KEY;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cpuResetReq = 1'b0;
    logic clkEn = 1'b1;
    logic dataReadoutLock = 1'b0;
    dewg_pkg::dewg_bus_type busReq = '0;
    logic [7:0] rdData_q;
    logic nvmBusy_q;
    logic pwrtRunning_q;
    logic extReadAllow_q;
    int fail_count = 0;
    int total_checks = 0;
    int n;

    always #4 sys_clk = ~sys_clk;

    // Clock enable stays high except for one freeze in the middle of a store
    dewg_top #(.PWRT_CYC(PWRT), .PROG_CYC(PROG)) dewg_top_inst (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .cpuResetReq(cpuResetReq),
        .dataReadoutLock(dataReadoutLock),
        .busReq(busReq),
        .rdData_q(rdData_q),
        .nvmBusy_q(nvmBusy_q),
        .pwrtRunning_q(pwrtRunning_q),
        .extReadAllow_q(extReadAllow_q)
    );

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    // Strobe then one idle cycle, so three writes give the exact key spacing
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        busReq <= '{wrStb: 1'b1, rdStb: 1'b0, addr: a, wrData: d};
        @(posedge sys_clk);
        busReq <= '0;
        @(posedge sys_clk);
    endtask

    task automatic rdck(input logic [2:0] a, input logic [7:0] exp, input string name);
        busReq <= '{wrStb: 1'b0, rdStb: 1'b1, addr: a, wrData: 8'h00};
        @(posedge sys_clk);
        busReq <= '0;
        #1;
        check(name, rdData_q, exp);
        @(posedge sys_clk);
    endtask

    task automatic unlock(input logic [7:0] ctl);
        wr(KEY, dewg_pkg::KEY_FIRST);
        wr(KEY, dewg_pkg::KEY_SECOND);
        wr(CTRL, ctl);
    endtask

    // Counts busy cycles left; a hang counts as a mismatch and ends the run
    task automatic busy_len(output int cnt);
        cnt = 0;
        #1;
        while (nvmBusy_q === 1'b1) begin
            cnt++;
            if (cnt > 200) begin
                check("busy timeout", 8'h01, 8'h00);
                tally_and_finish();
            end
            @(posedge sys_clk);
            #1;
        end
        @(posedge sys_clk);
    endtask

    task automatic t_pwrt();
        rdck(CTRL, 8'h00, "permit at power-up");
        wr(CTRL, 8'h04);
        unlock(8'h06);
        check("busy under timer", {7'h00, nvmBusy_q}, 8'h00);
        rdck(CTRL, 8'h04, "trigger under timer");
        n = 0;
        while (pwrtRunning_q !== 1'b0) begin
            n++;
            if (n > PWRT + 20) begin
                check("timer end", 8'h01, 8'h00);
                tally_and_finish();
            end
            idle(1);
        end
        $display("test pwrt done");
    endtask

    task automatic t_regs();
        for (int i = 0; i < 8; i++) begin
            if (i != 5) rdck(3'(i), 8'h00, "reset value");
        end
        wr(CORE, 8'h80);
        rdck(CORE, 8'h80, "core irq enable");
        wr(MASKS, 8'h80);
        rdck(MASKS, 8'h80, "done mask");
        $display("test regs done");
    endtask

    task automatic t_write();
        dataReadoutLock <= 1'b1;
        wr(LOC, 8'h5A);
        wr(BYTE, 8'hC3);
        wr(CORE, 8'h00);
        unlock(8'h06);
        busy_len(n);
        check("write length", 8'(n), 8'(PROG - 1));
        rdck(CTRL, 8'h04, "trigger cleared");
        rdck(FLAGS, 8'h80, "done flag");
        idle(5);
        rdck(FLAGS, 8'h80, "done sticky");
        wr(FLAGS, 8'h00);
        rdck(FLAGS, 8'h00, "done cleared");
        check("ext readout", {7'h00, extReadAllow_q}, 8'h00);
        // Second byte: permit dropped and registers poked while the store runs
        wr(LOC, 8'h5B);
        wr(BYTE, 8'h3C);
        unlock(8'h06);
        wr(CTRL, 8'h00);
        wr(BYTE, 8'h11);
        wr(LOC, 8'h00);
        busy_len(n);
        check("write length 2", 8'(n), 8'(PROG - 7));
        rdck(CTRL, 8'h00, "permit kept clear");
        rdck(LOC, 8'h5B, "location held");
        wr(LOC, 8'h5A);
        wr(CTRL, 8'h01);
        rdck(BYTE, 8'hC3, "read back 1");
        wr(LOC, 8'h5B);
        wr(CTRL, 8'h01);
        rdck(BYTE, 8'h3C, "read back 2");
        wr(KEY, dewg_pkg::KEY_FIRST);
        rdck(KEY, 8'h00, "key reads zero");
        dataReadoutLock <= 1'b0;
        idle(5);
        check("ext readout free", {7'h00, extReadAllow_q}, 8'h01);
        $display("test write done");
    endtask

    task automatic try_bad(input logic [7:0] k1, input logic [7:0] k2, input bit stray,
                           input int gap);
        wr(KEY, k1);
        if (stray) wr(MASKS, 8'h00);
        idle(gap);
        wr(KEY, k2);
        wr(CTRL, 8'h06);
        check("busy after bad unlock", {7'h00, nvmBusy_q}, 8'h00);
        rdck(CTRL, 8'h04, "trigger refused");
    endtask

    task automatic t_order();
        wr(CTRL, 8'h04);
        try_bad(8'hAA, 8'h55, 1'b0, 0);
        try_bad(8'h55, 8'hAA, 1'b1, 0);
        try_bad(8'h55, 8'hAA, 1'b0, 1);
        try_bad(8'h55, 8'h55, 1'b0, 0);
        wr(CTRL, 8'h06);
        check("trigger alone", {7'h00, nvmBusy_q}, 8'h00);
        unlock(8'h06);
        // Four frozen edges hand back the four cycles spent waiting here
        clkEn <= 1'b0;
        idle(4);
        clkEn <= 1'b1;
        busy_len(n);
        check("tracker recovered", 8'(n), 8'(PROG - 1));
        wr(CTRL, 8'h06);
        check("no second byte", {7'h00, nvmBusy_q}, 8'h00);
        $display("test order done");
    endtask

    task automatic t_permit();
        wr(CTRL, 8'h00);
        unlock(8'h02);
        check("busy without permit", {7'h00, nvmBusy_q}, 8'h00);
        rdck(CTRL, 8'h00, "trigger without permit");
        $display("test permit done");
    endtask

    task automatic t_warm();
        wr(LOC, 8'h10);
        wr(BYTE, 8'h77);
        wr(MASKS, 8'h80);
        wr(CTRL, 8'h04);
        unlock(8'h06);
        cpuResetReq <= 1'b1;
        @(posedge sys_clk);
        cpuResetReq <= 1'b0;
        @(posedge sys_clk);
        check("busy after warm reset", {7'h00, nvmBusy_q}, 8'h00);
        rdck(CTRL, 8'h08, "abort flag");
        rdck(LOC, 8'h00, "location cleared");
        rdck(BYTE, 8'h00, "byte cleared");
        rdck(FLAGS, 8'h00, "no done on abort");
        rdck(MASKS, 8'h00, "masks cleared");
        wr(LOC, 8'h5A);
        wr(CTRL, 8'h01);
        rdck(BYTE, 8'hC3, "store survives");
        wr(CTRL, 8'h00);
        rdck(CTRL, 8'h00, "abort cleared");
        $display("test warm done");
    endtask

    initial begin
        idle(12);
        check("busy in reset", {7'h00, nvmBusy_q}, 8'h00);
        check("timer in reset", {7'h00, pwrtRunning_q}, 8'h01);
        check("read data in reset", rdData_q, 8'h00);
        arst_n <= 1'b1;
        idle(3);
        t_pwrt();
        t_regs();
        t_write();
        t_order();
        t_permit();
        t_warm();
        tally_and_finish();
    end
endmodule
`default_nettype wire
